// ==== rtl/sep_top.sv ====
`timescale 1ns/1ps
module sep_top #(
  parameter int unsigned WORDS     = sep_pkg::MAX_WORDS,
  parameter int unsigned WR_CYCLES = sep_pkg::WR_CYC
) (
  input  wire logic REF_CLK_IN,
  input  wire logic RST_N_IN,
  input  wire logic SERIAL_CLOCK_IN,
  input  wire logic CHIP_SELECT_N_IN,
  input  wire logic SERIAL_DATA_IN,
  input  wire logic WRITE_RESET_IN,
  output logic      SERIAL_DATA_OUT,
  output logic      SERIAL_DATA_OE_OUT,
  output logic      READY_BUSY_N_OUT
);
  localparam int AW = $clog2(WORDS);
  localparam logic [31:0] ERASE_LD = 32'(WR_CYCLES / 2 - 1);
  localparam logic [31:0] PROG_LD  = 32'(WR_CYCLES - WR_CYCLES / 2 - 1);

  // =====================================================
  // link domain: serial clock, frame cleared by select
  logic [1:0]          lrs_q;
  wire                 link_rst_n = lrs_q[1];
  sep_pkg::sep_frame_e fs_q;
  logic [2:0]          win_q;
  logic [4:0]          cnt_q;
  logic [27:0]         sh_q;
  logic [3:0]          ridx_q;
  logic                seen1_q;
  logic [15:0]         rword_q;
  sep_pkg::sep_cmd_s   cmd_q;
  logic                ctog_q;
  logic                otog_q;
  logic                rd_oe_q;
  logic                rd_bit_q;
  logic [15:0]         mem_q [WORDS];

  wire [27:0] sh_d     = {sh_q[26:0], SERIAL_DATA_IN};
  wire        start_hit = {win_q, SERIAL_DATA_IN} == sep_pkg::START;
  wire        in_shift = fs_q == sep_pkg::FS_SHIFT;
  wire        opa_done = in_shift && cnt_q == 5'(sep_pkg::OPA_BITS - 1);
  wire        all_done = in_shift && cnt_q == 5'(sep_pkg::FULL_BITS - 1);
  wire [3:0]  opa_op   = sh_d[11:8];
  wire        is_rd    = opa_op == sep_pkg::OP_READ;
  wire        has_data = opa_op == sep_pkg::OP_WRIT
                      || opa_op == sep_pkg::OP_WRAL;
  wire [AW-1:0] rd_idx = sh_d[7 -: AW];
  wire        pub_ev   = (opa_done && !is_rd && !has_data) || all_done;
  wire        one_ev   = SERIAL_DATA_IN && !seen1_q;
  // short frames end after the address: move the opcode to the top field
  wire [27:0] pub_w    = opa_done ? {sh_d[11:0], 16'h0000} : sh_d;

  always_ff @(posedge SERIAL_CLOCK_IN) begin
    lrs_q <= {lrs_q[0], RST_N_IN};
  end

  // select high ends the frame even with the serial clock stopped
  always_ff @(posedge SERIAL_CLOCK_IN or posedge CHIP_SELECT_N_IN) begin
    if (CHIP_SELECT_N_IN) begin
      fs_q    <= sep_pkg::FS_HUNT;
      win_q   <= 3'h0;
      cnt_q   <= 5'h00;
      ridx_q  <= 4'h0;
      seen1_q <= 1'b0;
    end else begin
      win_q   <= {win_q[1:0], SERIAL_DATA_IN};
      seen1_q <= seen1_q | SERIAL_DATA_IN;
      case (fs_q)
        sep_pkg::FS_HUNT: begin
          if (start_hit) begin
            fs_q <= sep_pkg::FS_SHIFT;
          end
        end
        sep_pkg::FS_SHIFT: begin
          cnt_q <= cnt_q + 5'h01;
          if (opa_done && is_rd) begin
            fs_q <= sep_pkg::FS_RDOUT;
          end else if (pub_ev) begin
            fs_q <= sep_pkg::FS_DONE;
          end
        end
        sep_pkg::FS_RDOUT: begin
          ridx_q <= ridx_q + 4'h1;
          if (ridx_q == 4'hf) begin
            fs_q <= sep_pkg::FS_DONE;
          end
        end
        default: fs_q <= sep_pkg::FS_DONE;
      endcase
    end
  end

  // the array is written by the core domain whether or not a read frame is in flight,
  // and it is read here without a crossing
  always_ff @(posedge SERIAL_CLOCK_IN) begin
    sh_q <= sh_d;
    if (opa_done) begin
      rword_q <= mem_q[rd_idx];
    end
  end

  always_ff @(posedge SERIAL_CLOCK_IN) begin
    if (!link_rst_n) begin
      cmd_q  <= '0;
      ctog_q <= 1'b0;
      otog_q <= 1'b0;
    end else begin
      if (pub_ev) begin
        cmd_q  <= pub_w;
        ctog_q <= ~ctog_q;
      end
      if (one_ev && !CHIP_SELECT_N_IN) begin
        otog_q <= ~otog_q;
      end
    end
  end

  // read data changes on falling edges, MSB first
  always_ff @(negedge SERIAL_CLOCK_IN or posedge CHIP_SELECT_N_IN) begin
    if (CHIP_SELECT_N_IN) begin
      rd_oe_q  <= 1'b0;
      rd_bit_q <= 1'b0;
    end else begin
      rd_oe_q  <= fs_q == sep_pkg::FS_RDOUT;
      rd_bit_q <= rword_q[~ridx_q];
    end
  end

  // =====================================================
  // core domain: synchronisers
  logic [3:0] sy1_q;
  logic [3:0] sy2_q;
  logic       ctp_q;
  logic       otp_q;
  logic       csp_q;
  wire  [3:0] sy_in  = {ctog_q, otog_q, WRITE_RESET_IN, CHIP_SELECT_N_IN};
  wire        ev_cmd = sy2_q[3] ^ ctp_q;
  wire        ev_one = sy2_q[2] ^ otp_q;
  wire        wrst_s = sy2_q[1];
  wire        cs_lo  = ~sy2_q[0];
  wire        cs_fall = cs_lo && !csp_q;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      sy1_q <= 4'h1;
      sy2_q <= 4'h1;
      ctp_q <= 1'b0;
      otp_q <= 1'b0;
      csp_q <= 1'b0;
    end else begin
      sy1_q <= sy_in;
      sy2_q <= sy1_q;
      ctp_q <= sy2_q[3];
      otp_q <= sy2_q[2];
      csp_q <= cs_lo;
    end
  end

  // =====================================================
  // core domain: write sequencer
  sep_pkg::sep_wr_e st_q;
  sep_pkg::sep_wr_e st_d;
  logic [31:0]      tmr_q;
  logic             wen_q;
  logic             ab_q;
  logic             pend_q;
  logic [AW-1:0]    wa_q;
  logic [15:0]      wd_q;
  logic             wral_q;
  logic             st_oe_q;
  logic             st_bit_q;
  logic             rb_q;

  wire is_wr  = cmd_q.op == sep_pkg::OP_WRIT || cmd_q.op == sep_pkg::OP_WRAL;
  wire go     = ev_cmd && is_wr && wen_q && !wrst_s && !ab_q
             && st_q == sep_pkg::WS_IDLE;
  wire t_end  = tmr_q == 32'h0;
  wire e_done = st_q == sep_pkg::WS_ERASE && t_end && !wrst_s;
  wire p_done = st_q == sep_pkg::WS_PROG && t_end && !wrst_s;

  always_comb begin
    st_d = st_q;
    case (st_q)
      sep_pkg::WS_IDLE:  if (go) st_d = sep_pkg::WS_ERASE;
      sep_pkg::WS_ERASE: if (e_done) st_d = sep_pkg::WS_PROG;
      sep_pkg::WS_PROG:  if (p_done) st_d = sep_pkg::WS_IDLE;
      default:           st_d = sep_pkg::WS_IDLE;
    endcase
    if (wrst_s) begin
      st_d = sep_pkg::WS_IDLE;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      st_q     <= sep_pkg::WS_IDLE;
      tmr_q    <= 32'h0;
      wen_q    <= sep_pkg::WEN_RST;
      ab_q     <= 1'b0;
      pend_q   <= 1'b0;
      wa_q     <= '0;
      wd_q     <= 16'h0000;
      wral_q   <= 1'b0;
      st_oe_q  <= 1'b0;
      st_bit_q <= 1'b1;
      rb_q     <= 1'b1;
    end else begin
      st_q <= st_d;
      if (go) begin
        tmr_q <= ERASE_LD;
      end else if (e_done) begin
        tmr_q <= PROG_LD;
      end else if (!t_end) begin
        tmr_q <= tmr_q - 32'h1;
      end
      // write reset leaves the enable latch alone
      if (ev_cmd && cmd_q.op == sep_pkg::OP_ENABLE_WRITES_CMD) begin
        wen_q <= 1'b1;
      end else if (ev_cmd && cmd_q.op == sep_pkg::OP_DISABLE_WRITES_CMD) begin
        wen_q <= 1'b0;
      end
      ab_q   <= wrst_s || (ab_q && !cs_fall);
      pend_q <= go || (pend_q && !ev_one);
      if (go) begin
        wa_q   <= cmd_q.addr[7 -: AW];
        wd_q   <= cmd_q.data;
        wral_q <= cmd_q.op == sep_pkg::OP_WRAL;
      end
      st_oe_q  <= cs_lo && pend_q;
      st_bit_q <= st_d == sep_pkg::WS_IDLE;
      rb_q     <= st_d == sep_pkg::WS_IDLE;
    end
  end

  // an abort during erase keeps the old word, during program the
  // word is left erased: that is the corruption a busy reset risks
  always_ff @(posedge REF_CLK_IN) begin
    for (int i = 0; i < WORDS; i++) begin
      if ((e_done || p_done) && (wral_q || wa_q == AW'(i))) begin
        mem_q[i] <= e_done ? sep_pkg::ERASED : wd_q;
      end
    end
  end

  // =====================================================
  // pin outputs
  assign SERIAL_DATA_OUT    = rd_oe_q ? rd_bit_q : st_bit_q;
  assign SERIAL_DATA_OE_OUT = rd_oe_q | st_oe_q;
  assign READY_BUSY_N_OUT   = rb_q;

  // =====================================================
  // assertions
  property p_busy_low;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    go |=> !rb_q ##1 (!rb_q || $past(wrst_s));
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy not shown after write launch");

  property p_erase_prog;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    e_done |=> st_q == sep_pkg::WS_PROG && tmr_q == PROG_LD;
  endproperty
  a_erase_prog: assert property (p_erase_prog)
    else $error("program phase did not follow erase");

  property p_abort;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    wrst_s && st_q != sep_pkg::WS_IDLE
      |=> st_q == sep_pkg::WS_IDLE && rb_q && st_bit_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("write reset did not abort to ready");

  property p_wen_gate;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    ev_cmd && is_wr && !wen_q && st_q == sep_pkg::WS_IDLE
      |=> st_q == sep_pkg::WS_IDLE && rb_q;
  endproperty
  a_wen_gate: assert property (p_wen_gate)
    else $error("write ran while writes disabled");

  property p_disable_writes_cmd;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    ev_cmd && cmd_q.op == sep_pkg::OP_DISABLE_WRITES_CMD |=> !wen_q;
  endproperty
  a_disable_writes_cmd: assert property (p_disable_writes_cmd)
    else $error("disable command left writes enabled");

  property p_wen_hold;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !ev_cmd |=> wen_q == $past(wen_q);
  endproperty
  a_wen_hold: assert property (p_wen_hold)
    else $error("enable latch changed without a command");

  property p_status_z;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    !cs_lo |=> !st_oe_q;
  endproperty
  a_status_z: assert property (p_status_z)
    else $error("status driven while deselected");

  property p_entry_abort;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    ab_q && ev_cmd |=> st_q == sep_pkg::WS_IDLE && !pend_q;
  endproperty
  a_entry_abort: assert property (p_entry_abort)
    else $error("write ran after reset during entry");

  property p_prog_data;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    p_done |=> mem_q[$past(wa_q)] == $past(wd_q) || $past(wral_q);
  endproperty
  a_prog_data: assert property (p_prog_data)
    else $error("programmed word differs from data");

  c_write: cover property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    p_done);
  c_abort: cover property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    wrst_s && st_q == sep_pkg::WS_PROG);
  c_enable: cover property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    ev_cmd && cmd_q.op == sep_pkg::OP_ENABLE_WRITES_CMD);
  c_read: cover property (@(posedge SERIAL_CLOCK_IN)
    disable iff (CHIP_SELECT_N_IN) opa_done && is_rd);
endmodule

// ==== rtl/sep_pkg.sv ====
package sep_pkg;
  // =====================================================
  // frame layout
  localparam logic [3:0] START     = 4'ha;
  localparam int         OPA_BITS  = 12;
  localparam int         FULL_BITS = 28;
  localparam int         WORD_W    = 16;
  localparam int         ADDR_W    = 8;
  localparam int         MAX_WORDS = 256;

  // =====================================================
  // opcodes, first nibble after the start pattern
  localparam logic [3:0] OP_READ = 4'h8;
  localparam logic [3:0] OP_WRIT = 4'h4;
  localparam logic [3:0] OP_ENABLE_WRITES_CMD = 4'h3;
  localparam logic [3:0] OP_DISABLE_WRITES_CMD = 4'h0;
  localparam logic [3:0] OP_WRAL = 4'h1;

  // =====================================================
  // reset values and erased word
  localparam logic [15:0] ERASED  = 16'hffff;
  localparam logic        WEN_RST = 1'b0;

  // =====================================================
  // timing
  localparam int CLK_NS   = 10;
  localparam int T_WR_MS  = 10;
  localparam int WR_CYC   = (T_WR_MS * 1000000) / CLK_NS;

  typedef struct packed {
    logic [3:0]  op;
    logic [7:0]  addr;
    logic [15:0] data;
  } sep_cmd_s;

  typedef enum logic [1:0] {
    FS_HUNT  = 2'b00,
    FS_SHIFT = 2'b01,
    FS_RDOUT = 2'b11,
    FS_DONE  = 2'b10
  } sep_frame_e;

  typedef enum logic [1:0] {
    WS_IDLE  = 2'b00,
    WS_ERASE = 2'b01,
    WS_PROG  = 2'b11
  } sep_wr_e;
endpackage

// ==== testbench/sep_host.sv ====
`timescale 1ns/1ps
module sep_host (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      di_out,
  input  wire logic do_in,
  input  wire logic oe_in
);
  logic last_q;
  logic do_w;

  // =====================================================
  // released line shows the inverse of the last level
  assign do_w = oe_in ? do_in : ~last_q;
  initial begin
    last_q = 1'b0;
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    di_out = 1'b0;
  end
  always @(do_in or oe_in) begin
    if (oe_in) last_q = do_in;
  end

  // =====================================================
  // serial clock only runs inside frames or idle bursts
  task automatic sel(input logic v);
    cs_n_out = v;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      #7.5 sck_out = 1'b1;
      #7.5 sck_out = 1'b0;
    end
  endtask
  task automatic frame(input logic [31:0] bits, input int n,
                       output logic [15:0] rd, output logic mid);
    rd = 16'h0000;
    mid = 1'b0;
    cs_n_out = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      di_out = bits[31-i];
      #7.5 sck_out = 1'b1;
      if (i >= 16) rd[31-i] = do_w;
      if (i == 8) mid = oe_in;
      #7.5 sck_out = 1'b0;
    end
    #20 cs_n_out = 1'b1;
    di_out = ~di_out;
    #60;
  endtask
endmodule

// ==== testbench/sep_top_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module sep_top_tb_top;
  logic        ref_clk;
  logic        rst_n;
  logic        wr_rst;
  logic        sck;
  logic        cs_n;
  logic        di;
  logic        dout;
  logic        oe;
  logic        rb;
  logic [15:0] rd;
  logic        mid;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  always #5 ref_clk = ~ref_clk;
  sep_top #(.WR_CYCLES(40)) sep_top_inst (
    .REF_CLK_IN         (ref_clk),
    .RST_N_IN           (rst_n),
    .SERIAL_CLOCK_IN    (sck),
    .CHIP_SELECT_N_IN   (cs_n),
    .SERIAL_DATA_IN     (di),
    .WRITE_RESET_IN     (wr_rst),
    .SERIAL_DATA_OUT    (dout),
    .SERIAL_DATA_OE_OUT (oe),
    .READY_BUSY_N_OUT   (rb)
  );
  sep_host sep_host_inst (
    .sck_out  (sck),
    .cs_n_out (cs_n),
    .di_out   (di),
    .do_in    (dout),
    .oe_in    (oe)
  );

  // =====================================================
  // shared helpers
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] a,
                     input logic [15:0] d, input int n);
    sep_host_inst.frame({sep_pkg::START, op, a, d}, n, rd, mid);
  endtask
  task automatic set_wr_rst(input logic v);
    @(posedge ref_clk) wr_rst <= v;
  endtask
  task automatic refused(input string m);
    cycles(10);
    `CHK(rb, 1'b1, m)
  endtask

  // =====================================================
  // scenarios
  task automatic t_write(input logic [7:0] a, input logic [15:0] d,
                         input bit en);
    int c;
    c = 0;
    if (en) cmd(sep_pkg::OP_ENABLE_WRITES_CMD, 8'h00, 16'h0000, 16);
    cmd(sep_pkg::OP_WRIT, a, d, 32);
    `CHK(rb, 1'b0, "busy")
    sep_host_inst.sel(1'b0);
    cycles(5);
    `CHK({oe, dout}, 2'b10, "status busy")
    sep_host_inst.sel(1'b1);
    cycles(5);
    `CHK(oe, 1'b0, "status off")
    while (rb !== 1'b1 && c < 100) begin
      cycles(1);
      c++;
    end
    `CHK(c > 5 && c < 40, 1'b1, "busy length")
    sep_host_inst.sel(1'b0);
    cycles(5);
    `CHK({oe, dout}, 2'b11, "done one")
    sep_host_inst.sel(1'b1);
    cycles(5);
    cmd(sep_pkg::OP_READ, a, 16'h0000, 32);
    `CHK(rd, d, "read back")
    `CHK(mid, 1'b0, "status cleared")
    $display("test write done");
  endtask

  task automatic t_abort;
    cmd(sep_pkg::OP_ENABLE_WRITES_CMD, 8'h00, 16'h0000, 16);
    cmd(sep_pkg::OP_WRIT, 8'h00, 16'h0f0f, 32);
    set_wr_rst(1'b1);
    cycles(6);
    `CHK(rb, 1'b1, "abort ready")
    sep_host_inst.sel(1'b0);
    cycles(5);
    `CHK({oe, dout}, 2'b11, "abort ready out")
    sep_host_inst.sel(1'b1);
    set_wr_rst(1'b0);
    cycles(5);
    cmd(sep_pkg::OP_READ, 8'h00, 16'h0000, 32);
    `CHK(rd, 16'ha55a, "abort in erase")
    $display("test abort done");
  endtask

  task automatic t_entry;
    set_wr_rst(1'b1);
    cmd(sep_pkg::OP_ENABLE_WRITES_CMD, 8'h00, 16'h0000, 16);
    cmd(sep_pkg::OP_WRIT, 8'hff, 16'h1111, 32);
    refused("entry reset");
    `CHK({oe, mid}, 2'b00, "entry floats")
    cmd(sep_pkg::OP_READ, 8'hff, 16'h0000, 32);
    `CHK(rd, 16'h5aa5, "read under reset")
    set_wr_rst(1'b0);
    cycles(5);
    $display("test entry done");
  endtask

  task automatic t_wral;
    cmd(sep_pkg::OP_ENABLE_WRITES_CMD, 8'h00, 16'h0000, 16);
    cmd(sep_pkg::OP_WRAL, 8'h00, 16'h1357, 32);
    `CHK(rb, 1'b0, "write all busy")
    cycles(60);
    `CHK(rb, 1'b1, "write all ready")
    cmd(sep_pkg::OP_READ, 8'h00, 16'h0000, 32);
    `CHK(rd, 16'h1357, "write all low")
    cmd(sep_pkg::OP_READ, 8'hff, 16'h0000, 32);
    `CHK(rd, 16'h1357, "write all high")
    $display("test write all done");
  endtask

  task automatic t_disable;
    cmd(sep_pkg::OP_DISABLE_WRITES_CMD, 8'h00, 16'h0000, 16);
    cmd(sep_pkg::OP_WRIT, 8'h00, 16'h2222, 32);
    refused("write disabled");
    cmd(sep_pkg::OP_WRAL, 8'h00, 16'h1357, 32);
    refused("write all disabled");
    cmd(sep_pkg::OP_READ, 8'h00, 16'h0000, 32);
    `CHK(rd, 16'ha55a, "read after disable")
    $display("test disable done");
  endtask

  // =====================================================
  // run control
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    ref_clk = 1'b0;
    rst_n   = 1'b0;
    wr_rst  = 1'b0;
    // serial clock must also tick while reset is held
    sep_host_inst.idle(4);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    sep_host_inst.idle(3);
    cmd(sep_pkg::OP_WRIT, 8'hff, 16'h1234, 32);
    refused("power up disabled");
    t_write(8'h00, 16'ha55a, 1'b1);
    t_write(8'hff, 16'h5aa5, 1'b1);
    t_abort();
    t_entry();
    t_write(8'h7f, 16'h8001, 1'b0);
    t_disable();
    t_wral();
    final_report();
  end
endmodule
